// ---- design/scs_pkg.sv ----
// Purpose: Shared constants for the serial configuration port, both ends
// Assumes: 250 MHz system clock on both ends
// Notes:   Internal byte addresses are 11 bits: block bits then word address
package scs_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned SYS_CLK_NS    = 4;
  // One quarter of a bus bit; low and high phases each take two quarters
  localparam int unsigned SCL_PHASE_NS  = 650;
  localparam int unsigned SCL_PHASE_CYC = (SCL_PHASE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Address space
  localparam int unsigned ADDR_W         = 11;
  localparam logic [10:0] ADDR_LONG_DLY  = 11'h0c0;
  localparam logic [10:0] ADDR_SHORT_A   = 11'h0c1;
  localparam logic [10:0] ADDR_SHORT_B   = 11'h0c2;
  localparam logic [10:0] ADDR_CTRL_CODE = 11'h0e9;
  localparam int unsigned CTRL_CODE_LSB  = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset, and the index of the last bit in a byte
  localparam logic [3:0]  CTRL_CODE_RST  = 4'h1;
  localparam logic [7:0]  LONG_DLY_RST   = 8'hd0;
  localparam logic [7:0]  SHORT_DLY_RST  = 8'h7c;
  localparam logic [2:0]  BIT_LAST       = 3'h7;

endpackage

// ---- design/scs_bus_if.sv ----
// Purpose: Two-wire bus between the controller end and the target end
// Assumes: Controller is the only source of the clock line
// Notes:   Data line is wired-and of both open-drain drivers, high when released
`timescale 1ns/1ps
interface scs_bus_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Released line reads high
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

// ---- design/scs_host_end.sv ----
// Purpose: Bus controller issuing byte writes and random reads
// Assumes: One command at a time; target acknowledges within the bit time
// Notes:   Clock line made by a divider of the system clock
`timescale 1ns/1ps
module scs_host_end #(
  parameter int unsigned DIV_W = 8
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // Command request
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_read,
  input  wire logic [10:0] i_cmd_addr,
  input  wire logic [7:0]  i_cmd_wdata,
  input  wire logic [3:0]  i_ctrl_code,
  // Command answer
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic             o_nack,
  output logic [7:0]       o_rdata,
  // Bus
  scs_bus_if.host          bus
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} scs_hstate_type;

  localparam logic [DIV_W-1:0] PHASE_LAST = DIV_W'(scs_pkg::SCL_PHASE_CYC - 1);

  function automatic logic [7:0] ctrl_byte(input logic [3:0] code, input logic [2:0] blk, input logic rd);
    ctrl_byte = {code, blk, rd};
  endfunction

  scs_hstate_type   state_r;
  logic [DIV_W-1:0] div_r;
  logic [1:0]       ph_r;
  logic [2:0]       step_r;
  logic [3:0]       bit_r;
  logic [7:0]       tx_r;
  logic [7:0]       rx_r;
  logic             rd_r;
  logic [10:0]      addr_r;
  logic [7:0]       wdata_r;
  logic [3:0]       code_r;
  logic             scl_r;
  logic             oe_r;
  logic             scl_nxt;
  logic             oe_nxt;
  logic [1:0]       sda_sync_r;
  logic             tick;
  logic             last;

  assign tick = (state_r != H_IDLE) && (div_r == PHASE_LAST);
  assign last = tick && (ph_r == 2'h3);

  assign bus.scl         = scl_r;
  assign bus.host_sda_oe = oe_r;
  assign bus.host_sda_o  = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Data line synchroniser
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], bus.sda};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase divider
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= '0;
      ph_r  <= 2'h0;
    end else if (state_r == H_IDLE) begin
      div_r <= '0;
      ph_r  <= 2'h0;
    end else if (tick) begin
      div_r <= '0;
      ph_r  <= ph_r + 2'h1;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line levels per phase; data changes while the clock is low, except at start and stop, which move it while the clock is high
  always_comb begin
    scl_nxt = 1'b1;
    oe_nxt  = 1'b0;
    unique case (state_r)
      H_IDLE: begin
        scl_nxt = 1'b1;
        oe_nxt  = 1'b0;
      end
      H_START: begin
        scl_nxt = ph_r[1];
        oe_nxt  = (ph_r == 2'h3);
      end
      H_TX: begin
        scl_nxt = ph_r[1];
        oe_nxt  = (ph_r == 2'h0) ? oe_r : (bit_r < 4'h8) && !tx_r[7];
      end
      H_RX: begin
        scl_nxt = ph_r[1];
        oe_nxt  = 1'b0;
      end
      H_STOP: begin
        scl_nxt = ph_r[1];
        oe_nxt  = (ph_r == 2'h0) ? oe_r : (ph_r != 2'h3);
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_r <= 1'b1;
      oe_r  <= 1'b0;
    end else begin
      scl_r <= scl_nxt;
      oe_r  <= oe_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r     <= H_IDLE;
      step_r      <= 3'h0;
      bit_r       <= 4'h0;
      tx_r        <= 8'h00;
      rx_r        <= 8'h00;
      rd_r        <= 1'b0;
      addr_r      <= 11'h000;
      wdata_r     <= 8'h00;
      code_r      <= 4'h0;
      o_cmd_ready <= 1'b1;
      o_done      <= 1'b0;
      o_nack      <= 1'b0;
      o_rdata     <= 8'h00;
    end else begin
      o_done <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          if (i_cmd_valid && o_cmd_ready) begin
            rd_r        <= i_cmd_read;
            addr_r      <= i_cmd_addr;
            wdata_r     <= i_cmd_wdata;
            code_r      <= i_ctrl_code;
            step_r      <= 3'h0;
            o_nack      <= 1'b0;
            o_cmd_ready <= 1'b0;
            state_r     <= H_START;
          end
        end
        H_START: begin
          if (last) begin
            bit_r   <= 4'h0;
            tx_r    <= ctrl_byte(code_r, addr_r[10:8], step_r == 3'h3);
            state_r <= H_TX;
          end
        end
        H_TX: begin
          if (last && bit_r != 4'h8) begin
            bit_r <= bit_r + 4'h1;
            tx_r  <= {tx_r[6:0], 1'b0};
          end else if (last) begin
            bit_r <= 4'h0;
            if (sda_sync_r[1]) begin
              o_nack  <= 1'b1;
              state_r <= H_STOP;
            end else begin
              unique case (step_r)
                3'h0: begin
                  step_r <= 3'h1;
                  tx_r   <= addr_r[7:0];
                end
                3'h1: begin
                  if (rd_r) begin
                    step_r  <= 3'h3;
                    state_r <= H_START;
                  end else begin
                    step_r <= 3'h2;
                    tx_r   <= wdata_r;
                  end
                end
                3'h3: begin
                  step_r  <= 3'h4;
                  state_r <= H_RX;
                end
                default: begin
                  state_r <= H_STOP;
                end
              endcase
            end
          end
        end
        H_RX: begin
          if (last && bit_r != 4'h8) begin
            bit_r <= bit_r + 4'h1;
            rx_r  <= {rx_r[6:0], sda_sync_r[1]};
          end else if (last) begin
            o_rdata <= rx_r;
            state_r <= H_STOP;
          end
        end
        H_STOP: begin
          if (last) begin
            o_done      <= 1'b1;
            o_cmd_ready <= 1'b1;
            state_r     <= H_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ---- design/scs_dev_end.sv ----
// Purpose: Two-wire target port into the configuration byte space
// Assumes: Bus clock comes from the controller and is much slower than i_clk_sys
// Notes:   Only the three delay bytes and the control code byte are stored;
//          other addresses read as zero and ignore writes
`timescale 1ns/1ps

module scs_dev_end (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // Bus
  scs_bus_if.dev          bus,
  // Configuration targets
  output logic [7:0]      o_long_delay_cfg,
  output logic [7:0]      o_short_delay_a_cfg,
  output logic [7:0]      o_short_delay_b_cfg,
  output logic [3:0]      o_ctrl_code,
  // Write event
  output logic            o_wr_strobe
);

  typedef enum logic [3:0] {
    D_IDLE,
    D_CTRL,
    D_CTRL_ACK,
    D_WADDR,
    D_WADDR_ACK,
    D_WDATA,
    D_WDATA_ACK,
    D_RDATA,
    D_RACK,
    D_SKIP
  } scs_dstate_type;

  scs_dstate_type                 state_r;
  logic [1:0]                     scl_sync_r;
  logic [1:0]                     sda_sync_r;
  logic                           scl_q_r;
  logic                           sda_q_r;
  logic [7:0]                     shift_r;
  logic [2:0]                     bit_r;
  logic                           full_r;
  logic                           rw_r;
  logic [scs_pkg::ADDR_W-1:0]     ptr_r;
  logic                           oe_r;
  logic                           mack_r;
  logic                           scl_rise;
  logic                           scl_fall;
  logic                           start_cond;
  logic                           stop_cond;
  logic                           sda_in;
  logic                           commit;
  logic [7:0]                     rd_byte;
  logic [7:0]                     rd_next_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Read decode of the stored bytes
  function automatic logic [7:0] cfg_read(
    input logic [scs_pkg::ADDR_W-1:0] addr,
    input logic [7:0]                 long_d,
    input logic [7:0]                 short_a,
    input logic [7:0]                 short_b,
    input logic [3:0]                 code
  );
    cfg_read = 8'h00;
    if (addr == scs_pkg::ADDR_LONG_DLY) begin
      cfg_read = long_d;
    end else if (addr == scs_pkg::ADDR_SHORT_A) begin
      cfg_read = short_a;
    end else if (addr == scs_pkg::ADDR_SHORT_B) begin
      cfg_read = short_b;
    end else if (addr == scs_pkg::ADDR_CTRL_CODE) begin
      cfg_read[scs_pkg::CTRL_CODE_LSB +: 4] = code;
    end
  endfunction

  assign rd_byte      = cfg_read(ptr_r, o_long_delay_cfg, o_short_delay_a_cfg,
                                 o_short_delay_b_cfg, o_ctrl_code);
  assign rd_next_byte = cfg_read(ptr_r + 1'b1, o_long_delay_cfg, o_short_delay_a_cfg,
                                 o_short_delay_b_cfg, o_ctrl_code);

  assign bus.dev_sda_oe = oe_r;
  assign bus.dev_sda_o  = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and edge detect
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], bus.scl};
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      scl_q_r    <= scl_sync_r[1];
      sda_q_r    <= sda_sync_r[1];
    end
  end

  assign sda_in     = sda_sync_r[1];
  assign scl_rise   = scl_sync_r[1] && !scl_q_r;
  assign scl_fall   = !scl_sync_r[1] && scl_q_r;
  // Data moving while the clock stays high marks start or stop
  assign start_cond = scl_sync_r[1] && scl_q_r && sda_q_r && !sda_in;
  assign stop_cond  = scl_sync_r[1] && scl_q_r && !sda_q_r && sda_in;

  // Write takes effect on the same edge the acknowledge is driven
  assign commit = scl_fall && full_r && (state_r == D_WDATA);

  //////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= D_IDLE;
      shift_r <= 8'h00;
      bit_r   <= 3'h0;
      full_r  <= 1'b0;
      rw_r    <= 1'b0;
      ptr_r   <= '0;
      oe_r    <= 1'b0;
      mack_r  <= 1'b0;
    end else if (start_cond) begin
      // Pointer survives so a read can follow the address phase
      state_r <= D_CTRL;
      bit_r   <= 3'h0;
      full_r  <= 1'b0;
      oe_r    <= 1'b0;
    end else if (stop_cond) begin
      state_r <= D_IDLE;
      full_r  <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      unique case (state_r)
        D_IDLE, D_SKIP: begin
          oe_r <= 1'b0;
        end
        D_CTRL, D_WADDR, D_WDATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_in};
            bit_r   <= bit_r + 3'h1;
            full_r  <= (bit_r == scs_pkg::BIT_LAST);
          end else if (scl_fall && full_r) begin
            full_r <= 1'b0;
            unique case (state_r)
              D_CTRL: begin
                if (shift_r[7:4] == o_ctrl_code) begin
                  oe_r              <= 1'b1;
                  rw_r              <= shift_r[0];
                  ptr_r[10:8]       <= shift_r[3:1];
                  state_r           <= D_CTRL_ACK;
                end else begin
                  state_r <= D_SKIP;
                end
              end
              D_WADDR: begin
                ptr_r[7:0] <= shift_r;
                oe_r       <= 1'b1;
                state_r    <= D_WADDR_ACK;
              end
              default: begin
                oe_r    <= 1'b1;
                state_r <= D_WDATA_ACK;
              end
            endcase
          end
        end
        D_CTRL_ACK: begin
          if (scl_fall) begin
            bit_r <= 3'h0;
            if (rw_r) begin
              oe_r    <= !rd_byte[7];
              shift_r <= {rd_byte[6:0], 1'b0};
              state_r <= D_RDATA;
            end else begin
              oe_r    <= 1'b0;
              state_r <= D_WADDR;
            end
          end
        end
        D_WADDR_ACK: begin
          if (scl_fall) begin
            oe_r    <= 1'b0;
            bit_r   <= 3'h0;
            state_r <= D_WDATA;
          end
        end
        D_WDATA_ACK: begin
          if (scl_fall) begin
            // Further bytes land at following addresses
            oe_r    <= 1'b0;
            bit_r   <= 3'h0;
            ptr_r   <= ptr_r + 1'b1;
            state_r <= D_WDATA;
          end
        end
        D_RDATA: begin
          if (scl_rise) begin
            bit_r  <= bit_r + 3'h1;
            full_r <= (bit_r == scs_pkg::BIT_LAST);
          end else if (scl_fall && full_r) begin
            full_r  <= 1'b0;
            oe_r    <= 1'b0;
            state_r <= D_RACK;
          end else if (scl_fall) begin
            oe_r    <= !shift_r[7];
            shift_r <= {shift_r[6:0], 1'b0};
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            mack_r <= !sda_in;
          end else if (scl_fall) begin
            ptr_r <= ptr_r + 1'b1;
            bit_r <= 3'h0;
            if (mack_r) begin
              oe_r    <= !rd_next_byte[7];
              shift_r <= {rd_next_byte[6:0], 1'b0};
              state_r <= D_RDATA;
            end else begin
              state_r <= D_SKIP;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration store
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_long_delay_cfg    <= scs_pkg::LONG_DLY_RST;
      o_short_delay_a_cfg <= scs_pkg::SHORT_DLY_RST;
      o_short_delay_b_cfg <= scs_pkg::SHORT_DLY_RST;
      o_ctrl_code         <= scs_pkg::CTRL_CODE_RST;
    end else if (commit) begin
      if (ptr_r == scs_pkg::ADDR_LONG_DLY) begin
        o_long_delay_cfg <= shift_r;
      end
      if (ptr_r == scs_pkg::ADDR_SHORT_A) begin
        o_short_delay_a_cfg <= shift_r;
      end
      if (ptr_r == scs_pkg::ADDR_SHORT_B) begin
        o_short_delay_b_cfg <= shift_r;
      end
      if (ptr_r == scs_pkg::ADDR_CTRL_CODE) begin
        o_ctrl_code <= shift_r[scs_pkg::CTRL_CODE_LSB +: 4];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write event
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wr_strobe <= 1'b0;
    end else begin
      o_wr_strobe <= commit;
    end
  end

endmodule

// ---- design/scs_unused_guard.sv ----
`timescale 1ns/1ps

// ---- tb/scs_bus_asserts.sv ----
// Purpose: Concurrent checks on the two-wire link between both ends
// Assumes: Bus clock is made from i_clk_sys by the controller end
// Notes:   Watches the link plus the target's write strobe and code
`timescale 1ns/1ps
module scs_bus_asserts (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  // Link
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       dev_sda_o,
  input  wire logic       dev_sda_oe,
  // Target side
  input  wire logic       o_wr_strobe,
  input  wire logic [3:0] o_ctrl_code
);
  logic       scl_d_r;
  logic       sda_d_r;
  logic [4:0] cnt_r;
  logic [7:0] ctrl_r;
  logic       start_w;
  logic       rise_w;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  assign start_w = scl && scl_d_r && sda_d_r && !sda;
  assign rise_w  = scl && !scl_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // Bit counter since the last start and the first byte's bits
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 5'h1f;
    end else if (start_w) begin
      cnt_r <= 5'h00;
    end else if (rise_w && cnt_r != 5'h1f) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= 8'h00;
    end else if (rise_w && cnt_r < 5'h08) begin
      ctrl_r <= {ctrl_r[6:0], sda};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_DEV_OPEN_DRAIN: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("target drives the data line high");
  AST_STABLE_SCL_HIGH: assert property ((scl && scl_d_r) |-> $stable(dev_sda_oe))
    else $error("target changed data while clock high");
  AST_DEV_HOLD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:400] rise_w))
    else $error("target released data before clock rise");
  AST_STROBE_IN_ACK: assert property ($rose(o_wr_strobe) |-> dev_sda_oe && !scl)
    else $error("commit not inside acknowledge");
  AST_STROBE_PULSE: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe longer than one cycle");
  AST_ACK_SLOT: assert property (($rose(dev_sda_oe) && cnt_r < 5'h09) |-> cnt_r == 5'h08)
    else $error("target drove inside control byte");
  AST_NACK_MISMATCH: assert property ((cnt_r == 5'h08 && !scl && ctrl_r[7:4] != o_ctrl_code) |-> !dev_sda_oe)
    else $error("acknowledge on wrong control code");
  AST_ACK_MATCH: assert property (($fell(scl) && cnt_r == 5'h08 && ctrl_r[7:4] == o_ctrl_code) |-> ##[1:8] dev_sda_oe)
    else $error("no acknowledge on matching control byte");

  COV_COMMIT: cover property ($rose(o_wr_strobe));
  COV_RESTART: cover property (start_w && cnt_r == 5'h13);
  COV_MISMATCH: cover property (cnt_r == 5'h08 && !scl && ctrl_r[7:4] != o_ctrl_code);
endmodule

// ---- tb/serial_config_slave_port_tb.sv ----
// Purpose: Drives the controller end against the target end
// Assumes: Each command finishes within the bounded wait
// Notes:   A monitor gathers bytes and acknowledge bits off the wire
`timescale 1ns/1ps
module serial_config_slave_port_tb;
  logic        clk_sys = 1'b0;
  logic        arst_n;
  logic        cmd_valid;
  logic        cmd_read;
  logic [10:0] cmd_addr;
  logic [7:0]  cmd_wdata;
  logic [3:0]  ctrl_code;
  logic        cmd_ready;
  logic        done;
  logic        nack;
  logic [7:0]  rdata;
  logic [7:0]  long_cfg;
  logic [7:0]  short_a_cfg;
  logic [7:0]  short_b_cfg;
  logic [3:0]  code_out;
  logic        wr_strobe;
  logic [7:0]  mon_byte[$];
  logic        mon_ack[$];
  logic [8:0]  sh;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  at_strobe;
  int          nbit;
  int          strobe_cnt;
  int          error_cnt;
  int          checks_done;

  always #2 clk_sys = ~clk_sys;

  scs_bus_if u_scs_bus_if ();

  scs_host_end u_scs_host_end (
    .i_clk_sys   (clk_sys),
    .i_arst_n    (arst_n),
    .i_cmd_valid (cmd_valid),
    .i_cmd_read  (cmd_read),
    .i_cmd_addr  (cmd_addr),
    .i_cmd_wdata (cmd_wdata),
    .i_ctrl_code (ctrl_code),
    .o_cmd_ready (cmd_ready),
    .o_done      (done),
    .o_nack      (nack),
    .o_rdata     (rdata),
    .bus         (u_scs_bus_if)
  );

  scs_dev_end u_scs_dev_end (
    .i_clk_sys           (clk_sys),
    .i_arst_n            (arst_n),
    .bus                 (u_scs_bus_if),
    .o_long_delay_cfg    (long_cfg),
    .o_short_delay_a_cfg (short_a_cfg),
    .o_short_delay_b_cfg (short_b_cfg),
    .o_ctrl_code         (code_out),
    .o_wr_strobe         (wr_strobe)
  );

  scs_bus_asserts u_scs_bus_asserts (
    .i_clk_sys   (clk_sys),
    .i_arst_n    (arst_n),
    .scl         (u_scs_bus_if.scl),
    .sda         (u_scs_bus_if.sda),
    .dev_sda_o   (u_scs_bus_if.dev_sda_o),
    .dev_sda_oe  (u_scs_bus_if.dev_sda_oe),
    .o_wr_strobe (wr_strobe),
    .o_ctrl_code (code_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Wire monitor: nine bits per byte, restarted on every start
  always @(posedge clk_sys) begin
    scl_q = u_scs_bus_if.scl;
    sda_q = u_scs_bus_if.sda;
    #1;
    if (u_scs_bus_if.scl && scl_q && sda_q && !u_scs_bus_if.sda) begin
      nbit = 0;
    end else if (u_scs_bus_if.scl && !scl_q) begin
      sh = {sh[7:0], u_scs_bus_if.sda};
      nbit++;
      if (nbit == 9) begin
        mon_byte.push_back(sh[8:1]);
        mon_ack.push_back(sh[0]);
        nbit = 0;
      end
    end
    if (wr_strobe === 1'b1) begin
      strobe_cnt++;
      at_strobe = short_a_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_cmd(input logic rd, input logic [10:0] addr, input logic [7:0] wd, input logic [3:0] code);
    int n;
    mon_byte.delete();
    mon_ack.delete();
    strobe_cnt = 0;
    cmd_read  <= rd;
    cmd_addr  <= addr;
    cmd_wdata <= wd;
    ctrl_code <= code;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 30000) begin
      error_cnt++;
      $display("ERROR t=%0t command never finished", $time);
      end_of_test();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    nbit = 0;
    strobe_cnt = 0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 11'h000;
    cmd_wdata = 8'h00;
    ctrl_code = 4'h1;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    check(long_cfg, 8'hd0, "long delay reset");
    check(short_a_cfg, 8'h7c, "short a reset");
    check(short_b_cfg, 8'h7c, "short b reset");
    check({4'h0, code_out}, 8'h01, "code reset");
    // Block bits select another byte: stored byte untouched
    do_cmd(1'b0, 11'h4c1, 8'h5a, 4'h1);
    check(mon_byte[0], 8'h18, "control byte block 4");
    check(short_a_cfg, 8'h7c, "short a after block 4 write");
    check({7'h0, nack}, 8'h00, "nack block 4");
    check(strobe_cnt[7:0], 8'h01, "strobes block 4");
    do_cmd(1'b0, 11'h0c1, 8'ha5, 4'h1);
    check(mon_byte[0], 8'h10, "control byte write");
    check(mon_byte[1], 8'hc1, "word address");
    check(mon_byte[2], 8'ha5, "data byte");
    check({5'h0, mon_ack[0], mon_ack[1], mon_ack[2]}, 8'h00, "write acks");
    check(short_a_cfg, 8'ha5, "short a written");
    check(at_strobe, 8'ha5, "value at commit");
    check({7'h0, cmd_ready}, 8'h01, "ready after write");
    do_cmd(1'b0, 11'h0e9, 8'h05, 4'h1);
    check({4'h0, code_out}, 8'h05, "code reprogrammed");
    do_cmd(1'b1, 11'h0c1, 8'h00, 4'h5);
    check(mon_byte[0], 8'h50, "control byte new code");
    check(mon_byte[2], 8'h51, "read control byte");
    check({5'h0, mon_ack[0], mon_ack[1], mon_ack[2]}, 8'h00, "read acks");
    check(mon_byte[3], 8'ha5, "read data on wire");
    check(rdata, 8'ha5, "read data");
    check(strobe_cnt[7:0], 8'h00, "no commit in read");
    // Old code no longer matches
    do_cmd(1'b0, 11'h0c2, 8'h33, 4'h1);
    check({7'h0, nack}, 8'h01, "nack on mismatch");
    check({7'h0, mon_ack[0]}, 8'h01, "line released");
    check(short_b_cfg, 8'h7c, "short b kept");
    check(strobe_cnt[7:0], 8'h00, "no commit on mismatch");
    check(long_cfg, 8'hd0, "long delay kept");
    end_of_test();
  end
endmodule
